// ---- core/lcs_seq.sv ----
/*
 * single-cell lithium charge sequencer with input guard control and
 * an axi4-lite slave for control and status.
 * assumes synchronous comparator inputs, one 10 MHz clock, and a
 * synchronous active-low reset.
 */
// Contract
// - charge only above lockout and enabled
// - low battery starts trickle at ten percent
// - trickle until precondition level, then cc
// - cc to cv at regulation voltage
// - cv until termination current, then end
// - indicator on only while charging
// - over-voltage opens switch, raises fault together
// - over-voltage at enable keeps switch open
// - below lockout the switch opens
// - fault flag active low, immediate
// - fault held 10 ms after clearing
// - guard and charger enabled separately
// - guard enable active low, high opens
// - faults override guard enable toggling
// - switch starts 10 ms after good input
// - sleep until recharge threshold, then restart
`timescale 1ns/100ps
`default_nettype none
`include "lcs_cfg.svh"

module lcs_seq
	import lcs_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// comparator inputs and enable pins
	input  wire lcs_cmp_t    cmp_in,
	input  wire logic        input_guard_enable_n,
	input  wire logic        charger_enable,
	// analog control outputs
	output var  logic        pass_switch_on,
	output var  logic [7:0]  current_request_pct,
	output var  logic        cv_mode,
	output var  logic        indicator_oe,
	output var  logic        fault_flag_n_oe,
	output var  logic        fault_flag_n,
	// axi4-lite write address
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	// axi4-lite write response
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ==========================================================
	// register file and bus slave
	// ==========================================================
	logic [31:0] ctrl_q, ctrl_d;        // control register
	logic        aw_got_q, aw_got_d;    // write address held
	logic        w_got_q, w_got_d;      // write data held
	logic [3:0]  aw_q, aw_d;            // held write address
	logic [31:0] wd_q, wd_d;            // held write data
	logic [3:0]  ws_q, ws_d;            // held strobes
	logic        bv_q, bv_d;            // write response valid
	logic [1:0]  br_q, br_d;            // write response code
	logic        rv_q, rv_d;            // read data valid
	logic [31:0] rd_q, rd_d;            // read data
	logic [1:0]  rr_q, rr_d;            // read response code
	logic [31:0] stat_w;                // live status word
	logic        awr_q, awr_d;          // write address ready
	logic        wrdy_q, wrdy_d;        // write data ready
	logic        arr_q, arr_d;          // read address ready
	logic        foe_q, foe_d;          // fault pin pull-down enable

	// charge and guard state
	lcs_state_t             st_q, st_d;     // sequencer phase
	logic [`LCS_CNT_W-1:0]  blk_q, blk_d;   // fault blanking count
	logic [`LCS_CNT_W-1:0]  dly_q, dly_d;   // startup delay count
	logic                   sw_q, sw_d;     // pass switch
	logic                   flt_q, flt_d;   // fault flag, active low
	logic [7:0]             pct_q, pct_d;   // current request
	logic                   cv_q, cv_d;     // constant voltage mode
	logic                   ind_q, ind_d;   // indicator sink on

	// effective enables: pins combined with software control
	logic guard_off, chg_en, in_bad;
	always_comb begin
		guard_off = input_guard_enable_n | ctrl_q[`LCS_CTRL_GUARD_N];
		chg_en    = charger_enable & ctrl_q[`LCS_CTRL_CHG_EN];
		in_bad    = cmp_in.ov_trip | cmp_in.uv_low;
	end

	// status word assembly
	always_comb begin
		stat_w = 32'h0000_0000;
		stat_w[`LCS_STAT_STATE_HI:`LCS_STAT_STATE_LO] = st_q;
		stat_w[`LCS_STAT_SWITCH]  = sw_q;
		stat_w[`LCS_STAT_FAULT_N] = flt_q;
		stat_w[`LCS_STAT_IND]     = ind_q;
		stat_w[`LCS_STAT_OV]      = cmp_in.ov_trip;
		stat_w[`LCS_STAT_UV]      = cmp_in.uv_low;
	end

	// bus next-state: address and data in either order
	always_comb begin
		aw_got_d = aw_got_q;
		w_got_d  = w_got_q;
		aw_d = aw_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		br_d = br_q;
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		ctrl_d = ctrl_q;
		// capture write address
		if (s_axi_awvalid && !aw_got_q && !bv_q) begin
			aw_got_d = 1'b1;
			aw_d     = s_axi_awaddr;
		end
		// capture write data
		if (s_axi_wvalid && !w_got_q && !bv_q) begin
			w_got_d = 1'b1;
			wd_d    = s_axi_wdata;
			ws_d    = s_axi_wstrb;
		end
		// perform write once both halves are held
		if (aw_got_q && w_got_q && !bv_q) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bv_d     = 1'b1;
			if (aw_q == `LCS_ADDR_CTRL) begin
				br_d = `LCS_RESP_OKAY;
				for (int i = 0; i < 4; i++) begin
					if (ws_q[i]) begin
						ctrl_d[i*8 +: 8] = wd_q[i*8 +: 8];
					end
				end
			end else if (aw_q == `LCS_ADDR_STAT) begin
				br_d = `LCS_RESP_OKAY;  // status is read-only
			end else begin
				br_d = `LCS_RESP_SLVERR;
			end
		end else if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
		// read path
		if (s_axi_arvalid && !rv_q) begin
			rv_d = 1'b1;
			case (s_axi_araddr)
				`LCS_ADDR_CTRL: begin
					rd_d = ctrl_q;
					rr_d = `LCS_RESP_OKAY;
				end
				`LCS_ADDR_STAT: begin
					rd_d = stat_w;
					rr_d = `LCS_RESP_OKAY;
				end
				default: begin
					rd_d = 32'h0000_0000;
					rr_d = `LCS_RESP_SLVERR;
				end
			endcase
		end else if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
		end
		// ready flags registered so the ports come straight from flops
		awr_d  = !aw_got_d && !bv_d;
		wrdy_d = !w_got_d && !bv_d;
		arr_d  = !rv_d;
	end

	// ==========================================================
	// guard switch, fault flag and charge sequencer
	// ==========================================================
	always_comb begin
		st_d  = st_q;
		blk_d = blk_q;
		dly_d = dly_q;
		sw_d  = sw_q;
		flt_d = flt_q;
		if (cmp_in.ov_trip) begin
			flt_d = 1'b0;
			blk_d = `LCS_CNT_W'(`LCS_BLANK_CYC - 1);
		end else if (!flt_q) begin
			if (blk_q == '0) begin
				flt_d = 1'b1;
			end else begin
				blk_d = blk_q - 1'b1;
			end
		end
		if (in_bad || guard_off) begin
			sw_d  = 1'b0;
			dly_d = `LCS_CNT_W'(`LCS_START_CYC - 1);
		end else if (!sw_q) begin
			// startup delay once input is good
			if (dly_q == '0) begin
				sw_d = 1'b1;
			end else begin
				dly_d = dly_q - 1'b1;
			end
		end
		// no charge without supply and enable
		if (!sw_q || !chg_en || cmp_in.uv_low) begin
			st_d = LCS_IDLE;
		end else begin
			case (st_q)
				LCS_IDLE: begin
					if (cmp_in.bat_low) begin
						st_d = LCS_TRICKLE;
					end else if (cmp_in.bat_reg) begin
						st_d = LCS_CV;
					end else begin
						st_d = LCS_CC;
					end
				end
				LCS_TRICKLE: begin
					if (!cmp_in.bat_low) begin
						st_d = LCS_CC;
					end
				end
				LCS_CC: begin
					if (cmp_in.bat_reg) begin
						st_d = LCS_CV;
					end
				end
				LCS_CV: begin
					if (cmp_in.cur_term) begin
						st_d = LCS_SLEEP;
					end
				end
				LCS_SLEEP: begin
					if (cmp_in.bat_rch) begin
						st_d = LCS_IDLE;
					end
				end
				default: begin
					st_d = LCS_IDLE;
				end
			endcase
		end
	end

	// outputs decoded from the next phase so they stay registered
	always_comb begin
		pct_d = `LCS_ZERO_PCT;
		cv_d  = 1'b0;
		case (st_d)
			LCS_TRICKLE: pct_d = `LCS_TRICKLE_PCT;
			LCS_CC:      pct_d = `LCS_FULL_PCT;
			LCS_CV: begin
				pct_d = `LCS_FULL_PCT;
				cv_d  = 1'b1;
			end
			default:     pct_d = `LCS_ZERO_PCT;
		endcase
		ind_d = (st_d == LCS_TRICKLE) || (st_d == LCS_CC) || (st_d == LCS_CV);
		// pull the fault pin low while the flag is asserted
		foe_d = !flt_d;
	end

	// state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q   <= `LCS_CTRL_RST;
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			aw_q     <= '0;
			wd_q     <= '0;
			ws_q     <= '0;
			bv_q     <= 1'b0;
			br_q     <= `LCS_RESP_OKAY;
			rv_q     <= 1'b0;
			rd_q     <= '0;
			rr_q     <= `LCS_RESP_OKAY;
			st_q     <= LCS_IDLE;
			blk_q    <= '0;
			dly_q    <= `LCS_CNT_W'(`LCS_START_CYC - 1);
			sw_q     <= 1'b0;
			flt_q    <= 1'b1;
			pct_q    <= `LCS_ZERO_PCT;
			cv_q     <= 1'b0;
			ind_q    <= 1'b0;
			awr_q    <= 1'b1;
			wrdy_q   <= 1'b1;
			arr_q    <= 1'b1;
			foe_q    <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			aw_got_q <= aw_got_d;
			w_got_q  <= w_got_d;
			aw_q     <= aw_d;
			wd_q     <= wd_d;
			ws_q     <= ws_d;
			bv_q     <= bv_d;
			br_q     <= br_d;
			rv_q     <= rv_d;
			rd_q     <= rd_d;
			rr_q     <= rr_d;
			st_q     <= st_d;
			blk_q    <= blk_d;
			dly_q    <= dly_d;
			sw_q     <= sw_d;
			flt_q    <= flt_d;
			pct_q    <= pct_d;
			cv_q     <= cv_d;
			ind_q    <= ind_d;
			awr_q    <= awr_d;
			wrdy_q   <= wrdy_d;
			arr_q    <= arr_d;
			foe_q    <= foe_d;
		end
	end

	// output drive straight from flops
	always_comb begin
		pass_switch_on      = sw_q;
		current_request_pct = pct_q;
		cv_mode             = cv_q;
		indicator_oe        = ind_q;
		fault_flag_n        = flt_q;
		fault_flag_n_oe     = foe_q;
		s_axi_awready       = awr_q;
		s_axi_wready        = wrdy_q;
		s_axi_bvalid        = bv_q;
		s_axi_bresp         = br_q;
		s_axi_arready       = arr_q;
		s_axi_rvalid        = rv_q;
		s_axi_rdata         = rd_q;
		s_axi_rresp         = rr_q;
	end

	// ==========================================================
	// assertions
	// ==========================================================
	sequence s_ov_seen;
		cmp_in.ov_trip;
	endsequence
	sequence s_fault_low;
		!fault_flag_n ##1 !fault_flag_n;
	endsequence

	a_ov_fault_now: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ov_seen |=> s_fault_low) else $error("fault flag not asserted on over-voltage");
	a_ov_switch_off: assert property (@(posedge aclk) disable iff (!aresetn)
		cmp_in.ov_trip |=> !pass_switch_on) else $error("switch stayed on during over-voltage");
	a_uv_switch_off: assert property (@(posedge aclk) disable iff (!aresetn)
		cmp_in.uv_low |=> !pass_switch_on) else $error("switch on below lockout");
	a_guard_off: assert property (@(posedge aclk) disable iff (!aresetn)
		input_guard_enable_n |=> !pass_switch_on) else $error("switch on with guard disabled");
	a_fault_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		in_bad && !guard_off |=> !pass_switch_on) else $error("fault overridden by guard enable");
	a_start_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(pass_switch_on) |-> $past(dly_q) == '0) else $error("switch rose before startup delay");
	a_blank_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(fault_flag_n) |-> $past(blk_q) == '0 && !$past(cmp_in.ov_trip)) else $error("fault released early");
	a_no_charge: assert property (@(posedge aclk) disable iff (!aresetn)
		!charger_enable |=> !indicator_oe) else $error("charging while disabled");
	a_trickle_pct: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == LCS_TRICKLE |-> current_request_pct == `LCS_TRICKLE_PCT) else $error("trickle level wrong");
	a_cv_entry: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == LCS_CC && cmp_in.bat_reg && sw_q && chg_en && !cmp_in.uv_low |=> cv_mode)
		else $error("no cv after regulation voltage");
	a_term_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == LCS_CV && cmp_in.cur_term && sw_q && chg_en && !cmp_in.uv_low |=> !indicator_oe)
		else $error("indicator on after termination");
	a_ind_state: assert property (@(posedge aclk) disable iff (!aresetn)
		indicator_oe == (current_request_pct != `LCS_ZERO_PCT)) else $error("indicator mismatch");

endmodule // lcs_seq
`default_nettype wire

// ---- core/lcs_cfg.svh ----
/*
 * holds the constants of the charge sequencer: register offsets,
 * field positions, reset values and timing figures.
 * assumes inclusion by bare name from core/ and sim/.
 */
`ifndef LCS_CFG_SVH
`define LCS_CFG_SVH

// ==========================================================
// timing
// ==========================================================
`define LCS_CLK_HZ            10000000
`define LCS_BLANK_MS          10
`define LCS_START_MS          10
`define LCS_BLANK_CYC         ((`LCS_BLANK_MS * `LCS_CLK_HZ) / 1000)
`define LCS_START_CYC         ((`LCS_START_MS * `LCS_CLK_HZ) / 1000)
`define LCS_CNT_W             20

// ==========================================================
// current request, in percent of programmed constant current
// ==========================================================
`define LCS_TRICKLE_PCT       8'h0A
`define LCS_FULL_PCT          8'h64
`define LCS_ZERO_PCT          8'h00

// ==========================================================
// register map (byte addresses)
// ==========================================================
`define LCS_ADDR_CTRL         4'h0
`define LCS_ADDR_STAT         4'h4
`define LCS_ADDR_W            4

// control register fields
`define LCS_CTRL_CHG_EN       0
`define LCS_CTRL_GUARD_N      1
`define LCS_CTRL_RST          32'h0000_0002

// status register fields
`define LCS_STAT_STATE_LO     0
`define LCS_STAT_STATE_HI     6
`define LCS_STAT_SWITCH       8
`define LCS_STAT_FAULT_N      9
`define LCS_STAT_IND          10
`define LCS_STAT_OV           11
`define LCS_STAT_UV           12

// axi responses
`define LCS_RESP_OKAY         2'h0
`define LCS_RESP_SLVERR       2'h2

`endif

// ---- core/lcs_pkg.sv ----
/*
 * holds the types of the charge sequencer.
 * assumes lcs_cfg.svh for all numeric constants.
 */
package lcs_pkg;

	// charge phases, one-hot
	typedef enum logic [6:0] {
		LCS_IDLE    = 7'b0000001,
		LCS_TRICKLE = 7'b0000010,
		LCS_CC      = 7'b0000100,
		LCS_CV      = 7'b0001000,
		LCS_SLEEP   = 7'b0010000,
		LCS_WAITON  = 7'b0100000,
		LCS_OFF     = 7'b1000000
	} lcs_state_t;

	// synchronised comparator results
	typedef struct packed {
		logic uv_low;       // input below lockout, hysteresis done in analog
		logic ov_trip;      // input above over-voltage trip point
		logic bat_low;      // battery below precondition threshold
		logic bat_reg;      // battery at regulation voltage
		logic cur_term;     // charge current at termination level
		logic bat_rch;      // battery below recharge threshold
	} lcs_cmp_t;

endpackage

// ---- sim/lcs_cell_model.sv ----
/*
 * cell, source and host pull-up model for the charge sequencer.
 * assumes the sequencer's current request and cv outputs.
 */
`timescale 1ns/100ps
`default_nettype none
module lcs_cell_model
	import lcs_pkg::*;
(
	// clock
	input  wire logic       aclk,
	// sequencer side
	input  wire logic [7:0] pct,
	input  wire logic       cv,
	input  wire logic       flt_oe,
	// bench controls
	input  wire logic       ov,
	input  wire logic       uv,
	input  wire logic       drain,
	// comparators and host fault line
	output var  lcs_cmp_t   cmp,
	output var  logic       flt_line
);
	// ========
	// cell
	int mv  = 2900; // cell voltage in millivolts
	int cvn = 0;    // cycles spent in cv, current decays
	assign flt_line = flt_oe ? 1'b0 : 1'b1;
	// levels change only after an edge
	assign cmp = '{uv, ov, mv < 3000, mv >= 4200, cvn >= 50, mv < 4100};
	// cell charges with request, holds in cv, drains on demand
	always @(posedge aclk) begin
		if (drain)
			mv <= mv - 1;
		else if (!cv)
			mv <= mv + int'(pct) / 10;
		cvn <= cv ? cvn + 1 : 0;
	end
endmodule // lcs_cell_model
`default_nettype wire

// ---- sim/tb.sv ----
/*
 * self-checking bench of the charge sequencer.
 * assumes lcs_seq, lcs_cell_model and a 10 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lcs_cfg.svh"
module tb import lcs_pkg::*;;
	// ========
	// signals
	logic        aclk = 0, aresetn = 0, guard_n = 0, chg_en = 0;
	logic        ov = 0, uv = 0, drain = 0;
	logic        sw_on, cv, ind, f_oe, f_n, f_line;
	logic [7:0]  pct;
	lcs_cmp_t    cmp;
	logic [3:0]  aw_a = '0, w_s = '0, ar_a = '0;
	logic [31:0] w_d = '0, r_d;
	logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
	logic        aw_r, w_r, b_v, ar_r, r_v;
	logic [1:0]  b_resp, r_resp;
	int          n_errors = 0, checked = 0;
	lcs_seq lcs_seq_inst (.aclk(aclk), .aresetn(aresetn), .cmp_in(cmp),
		.input_guard_enable_n(guard_n), .charger_enable(chg_en),
		.pass_switch_on(sw_on), .current_request_pct(pct), .cv_mode(cv),
		.indicator_oe(ind), .fault_flag_n_oe(f_oe), .fault_flag_n(f_n),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
		.s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v),
		.s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
		.s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
		.s_axi_rvalid(r_v), .s_axi_rready(r_r));
	lcs_cell_model lcs_cell_model_inst (.aclk(aclk), .pct(pct), .cv(cv),
		.flt_oe(f_oe), .ov(ov), .uv(uv), .drain(drain), .cmp(cmp),
		.flt_line(f_line));
	// clock
	initial begin
		forever #50 aclk = ~aclk;
	end
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// axi write, channels released as taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		aw_a <= a;
		aw_v <= 1'b1;
		w_d <= d;
		w_s <= 4'hF;
		w_v <= 1'b1;
		b_r <= 1'b1;
		do begin
			@(posedge aclk);
			if (aw_r === 1'b1)
				aw_v <= 1'b0;
			if (w_r === 1'b1)
				w_v <= 1'b0;
			r = b_resp;
		end while (b_v !== 1'b1);
		// bready stays up between writes, never lowered and raised in one step
	endtask
	// axi read
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do begin
			@(posedge aclk);
			if (ar_r === 1'b1)
				ar_v <= 1'b0;
			d = r_d;
			r = r_resp;
		end while (r_v !== 1'b1);
		// rready stays up between reads, never lowered and raised in one step
	endtask
	// register map, reset values, refusals
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		rd(`LCS_ADDR_CTRL, d, r);
		chk(d, `LCS_CTRL_RST);
		rd(4'h8, d, r);
		chk(r, `LCS_RESP_SLVERR);
		chk(d, 0);
		wr(4'h8, 32'h1, r);
		chk(r, `LCS_RESP_SLVERR);
		wr(`LCS_ADDR_STAT, 32'hFFFFFFFF, r);
		chk(r, `LCS_RESP_OKAY);
		rd(`LCS_ADDR_STAT, d, r);
		chk(d[`LCS_STAT_SWITCH], 0);
		chk(sw_on, 0);
	endtask
	// full charge cycle and recharge
	task automatic t_charge;
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		wr(`LCS_ADDR_CTRL, 32'h1, r);
		repeat (5) @(posedge aclk);
		chk(pct, 0);
		chg_en <= 1'b1;
		for (n = 0; pct === 8'h00 && n < 20; n++) @(posedge aclk);
		chk(pct, `LCS_TRICKLE_PCT);
		chk(ind, 1);
		chk(cmp.bat_low, 1);
		for (n = 0; pct === `LCS_TRICKLE_PCT && n < 300; n++) @(posedge aclk);
		chk(pct, `LCS_FULL_PCT);
		chk(cmp.bat_low, 0);
		for (n = 0; cv !== 1'b1 && n < 300; n++) @(posedge aclk);
		chk(cmp.bat_reg, 1);
		chk(pct, `LCS_FULL_PCT);
		for (n = 0; ind !== 1'b0 && n < 300; n++) @(posedge aclk);
		chk(cmp.cur_term, 1);
		chk(pct, 0);
		chk(cv, 0);
		rd(`LCS_ADDR_STAT, d, r);
		chk(d[6:0], 7'h10);
		drain <= 1'b1;
		for (n = 0; pct === 8'h00 && n < 300; n++) @(posedge aclk);
		chk(cmp.bat_rch, 1);
		chk(pct, `LCS_FULL_PCT);
		drain <= 1'b0;
	endtask
	// guard pin and lockout open the switch
	task automatic t_guard;
		guard_n <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(sw_on, 0);
		chk(ind, 0);
		guard_n <= 1'b0;
		uv <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(sw_on, 0);
		uv <= 1'b0;
	endtask
	// over-voltage at enable, override, then blanking and startup delay together
	task automatic t_fault;
		logic [1:0] r;
		int         n, nf, ns;
		ov <= 1'b1;
		wr(`LCS_ADDR_CTRL, 32'h0, r);
		chk(f_n, 0);
		chk(f_line, 0);
		chk(sw_on, 0);
		repeat (4) begin
			guard_n <= ~guard_n;
			@(posedge aclk);
			chk(sw_on, 0);
		end
		// both 10 ms counts start at the first edge that sees the input good
		ov <= 1'b0;
		n = 0;
		nf = 0;
		ns = 0;
		while ((f_n !== 1'b1 || sw_on !== 1'b1) && n < 100100) begin
			@(posedge aclk);
			n++;
			if (f_n === 1'b1 && nf == 0)
				nf = n;
			if (sw_on === 1'b1 && ns == 0)
				ns = n;
		end
		chk(nf > 99989 && nf < 100011, 1);
		chk(ns > 99899 && ns < 100011, 1);
		chk(pct, 0);
		chk(ind, 0);
	endtask
	// verdict and end of run
	task automatic wrap_up;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watchdog: the two 10 ms counts overlap, so the run needs about 101k cycles
	initial begin
		#11000000;
		n_errors++;
		wrap_up;
	end
	// main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_fault;
		t_charge;
		t_guard;
		wrap_up;
	end
endmodule // tb
`default_nettype wire
